// >>> core/timer_one_cfg.svh
// Offsets, field positions, reset values and timing counts of the 16-bit timer.
`ifndef TIMER_ONE_CFG_SVH
`define TIMER_ONE_CFG_SVH

// Byte addresses on the register bus.
`define OFS_COUNT_LOW 8'h00
`define OFS_COUNT_HIGH 8'h04
`define OFS_FLAG_REG 8'h08
`define OFS_ENABLE_REG 8'h0c
`define OFS_CONTROL 8'h10

// Bit positions in the control register.
`define BIT_COUNTER_ON 0
`define BIT_CLOCK_SRC 1
`define BIT_SYNC_DIS 2
`define BIT_OSC_EN 3
`define BIT_PRESCALE_LO 4
`define BIT_STATUS 6

// Bit position of the overflow flag and of its enable.
`define BIT_OVERFLOW 0

// Reset values and masks.
`define CONTROL_RESET 8'h00
`define CONTROL_WR_MASK 8'h3f
`define COUNT_RESET 16'h0000
`define COUNT_ALL_ONES 16'hffff

// System clock select code for the timer oscillator.
`define SCS_TIMER_OSC 2'h1

// Core clock cycles per instruction cycle (Fosc/4).
`define INSN_CYCLES 4

`endif

// >>> core/timer_one_pkg.sv
// Types shared by the 16-bit timer files.
package timer_one_pkg;

	// Control register layout, bit 7 down to bit 0.
	typedef struct packed {
		logic unused;
		logic sysclk_from_timer_osc;
		logic [1:0] input_prescale_sel;
		logic crystal_osc_enable;
		logic ext_sync_disable;
		logic clock_source_sel;
		logic counter_on;
	} control_t;

	// The two crystal pins, input pin high, output pin low.
	typedef struct packed {
		logic crystal_in_pin;
		logic crystal_out_pin;
	} osc_pins_t;

	// What advances the count.
	typedef enum logic [1:0] {MODE_TIMER, MODE_SYNC_COUNT, MODE_ASYNC_COUNT} mode_t;

endpackage

// >>> core/prescale_div.sv
// Input prescaler that passes one of every 1, 2, 4 or 8 ticks.
module prescale_div #(
	parameter int SEL_W = 2
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clear_i,
	input wire logic [SEL_W-1:0] sel_i,
	input wire logic tick_i,
	output logic tick_o
);
	localparam int CNT_W = (1 << SEL_W) - 1;

	// Refuse selector widths the counter cannot serve.
	if (SEL_W < 1 || SEL_W > 3) begin : g_bad_sel
		$error("prescale_div: SEL_W must be 1 to 3");
	end

	logic [CNT_W-1:0] div_ff;
	logic [CNT_W-1:0] mask;

	// Low bits of the divider that must all be set for a tick to pass.
	function automatic logic [CNT_W-1:0] low_mask(input logic [SEL_W-1:0] sel);
		low_mask = CNT_W'((1 << sel) - 1);
	endfunction

	// Pass a tick when the selected low bits of the divider are all ones.
	assign mask = low_mask(sel_i);
	assign tick_o = tick_i && ((div_ff & mask) == mask);

	// Divider advances on each input tick and restarts on clear.
	always_ff @(posedge clk_i) begin
		if (rst_i || clear_i) begin
			div_ff <= '0;
		end else if (tick_i) begin
			div_ff <= div_ff + 1'b1;
		end
	end
endmodule // prescale_div

// >>> core/timer_one.sv
// 16-bit timer/counter with prescaler, crystal oscillator control and Wishbone registers.
// What this block does
// - 16-bit count in two bytes, wraps to zero.
// - Wrap sets overflow flag until software clears.
// - Overflow interrupt passes only when enable set.
// - Control bit 6 shows timer oscillator clocking system.
// - Status set when oscillator on and select 01.
// - Status follows real clock source under fail-safe.
// - Timer, synchronous or asynchronous counter modes.
// - Timer mode counts once per instruction cycle.
// - External mode counts rising pin edges only.
// - Counter on bit runs or holds count.
// - Prescale bits divide by 1, 2, 4, 8.
// - Oscillator enable bit powers crystal inverter.
// - Oscillator enabled forces pins input, reads zero.
// - Special event trigger clears the count.
// - Oscillator keeps running in power-managed modes.
// - Special event reset never sets overflow flag.
`include "timer_one_cfg.svh"

module timer_one #(
	parameter int INSN_CYCLES = `INSN_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic ext_count_pin_i,
	input wire logic special_event_i,
	input wire logic [1:0] system_clock_select_i,
	input wire logic osc_running_i,
	input wire timer_one_pkg::osc_pins_t port_direction_reg_i,
	input wire timer_one_pkg::osc_pins_t port_data_i,
	input wire timer_one_pkg::osc_pins_t pin_level_i,
	output timer_one_pkg::osc_pins_t pin_oe_o,
	output timer_one_pkg::osc_pins_t pin_out_o,
	output timer_one_pkg::osc_pins_t port_read_o,
	output logic crystal_drive_o,
	output logic overflow_irq_o,
	output logic sysclk_from_timer_osc_o
);
	import timer_one_pkg::*;

	// Refuse an instruction divider the phase counter cannot serve.
	if (INSN_CYCLES < 1 || INSN_CYCLES > 16) begin : g_bad_insn
		$error("timer_one: INSN_CYCLES must be 1 to 16");
	end

	control_t ctrl_ff;
	logic [15:0] count_ff;
	logic overflow_flag_ff;
	logic overflow_irq_enable_ff;
	logic ack_ff;
	logic [31:0] rdata_ff;
	logic [3:0] meta_ff;
	logic [3:0] sync_ff;
	logic edge_prev_ff;
	logic edge_pend_ff;
	logic [3:0] phase_ff;
	logic irq_ff;
	logic status_ff;
	logic drive_ff;
	osc_pins_t oe_ff;
	osc_pins_t out_ff;
	osc_pins_t read_ff;

	logic bus_hit;
	logic bus_wr;
	logic wr_low;
	logic wr_high;
	logic wr_count;
	logic wr_flag;
	logic insn_tick;
	logic src_level;
	logic rise;
	logic raw_tick;
	logic pre_tick;
	logic inc;
	logic wrap;
	mode_t mode;
	osc_pins_t pin_sync;

	// True when an access targets the given register.
	function automatic logic addr_is(input logic [7:0] adr, input logic [7:0] ofs);
		addr_is = (adr == ofs);
	endfunction

	// A request is answered one cycle after it is first seen; a write lands at the
	// edge where the master samples that answer, while it still holds the request.
	assign bus_hit = wb_cyc_i && wb_stb_i && !ack_ff;
	assign bus_wr = wb_cyc_i && wb_stb_i && ack_ff && wb_we_i && wb_sel_i[0];
	assign wr_low = bus_wr && addr_is(wb_adr_i, `OFS_COUNT_LOW);
	assign wr_high = bus_wr && addr_is(wb_adr_i, `OFS_COUNT_HIGH);
	assign wr_count = wr_low || wr_high;
	assign wr_flag = bus_wr && addr_is(wb_adr_i, `OFS_FLAG_REG);

	// Acknowledge a single-cycle pulse for every access, mapped or not.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= bus_hit;
		end
	end

	// Read data is latched with the acknowledge; unmapped reads give zero.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_ff <= 32'h0000_0000;
		end else if (bus_hit && !wb_we_i) begin
			unique case (wb_adr_i)
				`OFS_COUNT_LOW: rdata_ff <= {24'h00_0000, count_ff[7:0]};
				`OFS_COUNT_HIGH: rdata_ff <= {24'h00_0000, count_ff[15:8]};
				`OFS_FLAG_REG: rdata_ff <= {31'h0000_0000, overflow_flag_ff};
				`OFS_ENABLE_REG: rdata_ff <= {31'h0000_0000, overflow_irq_enable_ff};
				`OFS_CONTROL: rdata_ff <= {24'h00_0000, 1'b0, ctrl_ff[6:0]};
				default: rdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	// Control register: bit 6 is status only, bit 7 never stores.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_ff <= `CONTROL_RESET;
		end else begin
			if (bus_wr && addr_is(wb_adr_i, `OFS_CONTROL)) begin
				ctrl_ff[5:0] <= 6'(wb_dat_i[7:0] & `CONTROL_WR_MASK);
			end
			ctrl_ff.sysclk_from_timer_osc <= status_ff;
			ctrl_ff.unused <= 1'b0;
		end
	end

	// Overflow enable bit.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			overflow_irq_enable_ff <= 1'b0;
		end else if (bus_wr && addr_is(wb_adr_i, `OFS_ENABLE_REG)) begin
			overflow_irq_enable_ff <= wb_dat_i[`BIT_OVERFLOW];
		end
	end

	// Every pin and the oscillator monitor pass two flip-flops first.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_ff <= 4'h0;
			sync_ff <= 4'h0;
		end else begin
			meta_ff <= {osc_running_i, pin_level_i, ext_count_pin_i};
			sync_ff <= meta_ff;
		end
	end
	assign pin_sync = sync_ff[2:1];

	// Instruction-cycle strobe, one core cycle in every INSN_CYCLES.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_ff <= 4'h0;
		end else if (phase_ff == 4'(INSN_CYCLES - 1)) begin
			phase_ff <= 4'h0;
		end else begin
			phase_ff <= phase_ff + 4'h1;
		end
	end
	assign insn_tick = (phase_ff == 4'(INSN_CYCLES - 1));

	// Operating mode from the source and synchronisation bits.
	always_comb begin
		if (!ctrl_ff.clock_source_sel) begin
			mode = MODE_TIMER;
		end else if (ctrl_ff.ext_sync_disable) begin
			mode = MODE_ASYNC_COUNT;
		end else begin
			mode = MODE_SYNC_COUNT;
		end
	end

	// With the crystal running the count comes from its input pin.
	assign src_level = ctrl_ff.crystal_osc_enable ? pin_sync.crystal_in_pin : sync_ff[0];

	// Only rising edges of the external source count.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			edge_prev_ff <= 1'b0;
		end else begin
			edge_prev_ff <= src_level;
		end
	end
	assign rise = src_level && !edge_prev_ff;

	// In synchronous mode an edge waits for the next instruction cycle.
	// A new edge in the cycle the pending one is used keeps it pending.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			edge_pend_ff <= 1'b0;
		end else if (rise) begin
			edge_pend_ff <= 1'b1;
		end else if (insn_tick) begin
			edge_pend_ff <= 1'b0;
		end
	end

	// Raw tick before the prescaler for each mode.
	always_comb begin
		unique case (mode)
			MODE_TIMER: raw_tick = insn_tick;
			MODE_SYNC_COUNT: raw_tick = edge_pend_ff && insn_tick;
			MODE_ASYNC_COUNT: raw_tick = rise;
		endcase
	end

	// Prescaler restarts while stopped, on a count write or on the trigger.
	prescale_div #(
		.SEL_W(2)
	) u_prescale (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clear_i(!ctrl_ff.counter_on || wr_count || special_event_i),
		.sel_i(ctrl_ff.input_prescale_sel),
		.tick_i(raw_tick && ctrl_ff.counter_on),
		.tick_o(pre_tick)
	);

	// A tick counts only while the counter is on; a wrap needs a plain increment.
	assign inc = pre_tick && ctrl_ff.counter_on;
	assign wrap = inc && (count_ff == `COUNT_ALL_ONES) && !special_event_i && !wr_count;

	// Trigger reset beats a write, a write beats counting.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_ff <= `COUNT_RESET;
		end else if (special_event_i) begin
			count_ff <= `COUNT_RESET;
		end else if (wr_low) begin
			count_ff[7:0] <= wb_dat_i[7:0];
		end else if (wr_high) begin
			count_ff[15:8] <= wb_dat_i[7:0];
		end else if (inc) begin
			count_ff <= count_ff + 16'h0001;
		end
	end

	// Overflow flag: a wrap in the same cycle as a clear keeps it set.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			overflow_flag_ff <= 1'b0;
		end else if (wrap) begin
			overflow_flag_ff <= 1'b1;
		end else if (wr_flag) begin
			overflow_flag_ff <= wb_dat_i[`BIT_OVERFLOW];
		end
	end

	// Interrupt line is the flag gated by its enable.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= overflow_flag_ff && overflow_irq_enable_ff;
		end
	end

	// Status shows the source actually clocking the system, so a failed
	// crystal under the clock monitor drops it three core clocks later.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_ff <= 1'b0;
		end else begin
			status_ff <= ctrl_ff.crystal_osc_enable && sync_ff[3]
				&& (system_clock_select_i == `SCS_TIMER_OSC);
		end
	end

	// The inverter follows the enable bit alone, so power modes never stop it.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			drive_ff <= 1'b0;
		end else begin
			drive_ff <= ctrl_ff.crystal_osc_enable;
		end
	end

	// With the crystal on, both pins are inputs and port reads give zero.
	// A direction bit of one means input.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			oe_ff <= 2'h0;
			out_ff <= 2'h0;
			read_ff <= 2'h0;
		end else begin
			out_ff <= port_data_i;
			if (ctrl_ff.crystal_osc_enable) begin
				oe_ff <= 2'h0;
				read_ff <= 2'h0;
			end else begin
				oe_ff <= ~port_direction_reg_i;
				read_ff <= pin_sync;
			end
		end
	end

	// Every output comes straight from its flip-flop.
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdata_ff;
	assign overflow_irq_o = irq_ff;
	assign sysclk_from_timer_osc_o = status_ff;
	assign crystal_drive_o = drive_ff;
	assign pin_oe_o = oe_ff;
	assign pin_out_o = out_ff;
	assign port_read_o = read_ff;

	// The checks below all run on the core clock and pause during reset.
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_count_wrap: assert property (wrap |=> count_ff == `COUNT_RESET)
		else $error("count did not wrap to zero");

	a_flag_set: assert property (wrap |=> overflow_flag_ff)
		else $error("wrap did not set overflow flag");

	a_flag_hold: assert property (overflow_flag_ff && !wr_flag |=> overflow_flag_ff)
		else $error("overflow flag dropped without a clear");

	a_irq_mask: assert property (!overflow_irq_enable_ff |=> !overflow_irq_o)
		else $error("masked overflow reached the interrupt line");

	a_irq_pass: assert property (overflow_flag_ff && overflow_irq_enable_ff |=> overflow_irq_o)
		else $error("enabled overflow did not reach the interrupt line");

	a_status_src: assert property (sysclk_from_timer_osc_o |->
		$past(ctrl_ff.crystal_osc_enable) && $past(system_clock_select_i) == `SCS_TIMER_OSC)
		else $error("status set without the timer oscillator selected");

	a_timer_rate: assert property (mode == MODE_TIMER && inc |=> !inc [*3])
		else $error("timer counted faster than the instruction rate");

	a_hold_off: assert property (!ctrl_ff.counter_on && !special_event_i && !wr_count
		|=> $stable(count_ff))
		else $error("count moved while stopped");

	a_pin_input: assert property (ctrl_ff.crystal_osc_enable |=> pin_oe_o == 2'h0
		&& port_read_o == 2'h0)
		else $error("crystal pins not forced to input");

	a_event_reset: assert property (special_event_i |=> count_ff == `COUNT_RESET
		&& !$rose(overflow_flag_ff))
		else $error("trigger did not clear the count cleanly");

	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("acknowledge held longer than one cycle");

	c_overflow: cover property (wrap ##2 overflow_irq_o);
	c_ext_count: cover property (mode == MODE_ASYNC_COUNT && inc);
	c_sync_count: cover property (mode == MODE_SYNC_COUNT && inc);
	c_event: cover property (special_event_i && ctrl_ff.counter_on);
endmodule // timer_one

// >>> tb/ext_clock_src.sv
// Model of the external count source and the low-power watch crystal.
module ext_clock_src (
	input wire logic drive_i,
	input wire logic fail_i,
	output logic ext_pin_o,
	output timer_one_pkg::osc_pins_t xtal_o,
	output logic running_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import timer_one_pkg::*;
	logic up;
	// The count pin idles low between bursts, and the crystal starts still.
	initial begin
		ext_pin_o = 1'b0;
		xtal_o = '0;
		up = 1'b0;
	end
	// The crystal swings only while its inverter is powered.
	always begin
		#500;
		xtal_o.crystal_in_pin = drive_i ? ~xtal_o.crystal_in_pin : 1'b0;
		xtal_o.crystal_out_pin = drive_i & ~xtal_o.crystal_in_pin;
	end
	// The clock monitor reports a good crystal only after its start-up time.
	always @(drive_i) begin
		up = 1'b0;
		if (drive_i) up <= #2000 1'b1;
	end
	assign running_o = up & drive_i & ~fail_i;
	// Sends a burst of n clean pulses, unrelated in phase to the core clock.
	task pulses(input int n);
		repeat (n) begin
			#163 ext_pin_o = 1'b1;
			#163 ext_pin_o = 1'b0;
		end
	endtask
endmodule // ext_clock_src

// >>> tb/sixteen_bit_timer_counter_tb.sv
// Self-checking bench for the 16-bit timer over its Wishbone registers.
`include "timer_one_cfg.svh"
module sixteen_bit_timer_counter_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import timer_one_pkg::*;
	logic clk_i, rst_i, we, cyc, stb, sev, fail, ack;
	logic [7:0] adr;
	logic [31:0] dat, rdat;
	logic [1:0] system_clock_select;
	osc_pins_t dir, pdat, lvl, oe, pout, prd, xtal;
	logic ext, drv, run, irq, stat;
	logic [31:0] exp_q[$];
	int tol_q[$];
	int err_total, checked, seed, n;
	logic [31:0] e;
	int t;
	timer_one uut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat),
		.wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
		.wb_ack_o(ack), .ext_count_pin_i(ext), .special_event_i(sev),
		.system_clock_select_i(system_clock_select), .osc_running_i(run), .port_direction_reg_i(dir),
		.port_data_i(pdat), .pin_level_i(lvl), .pin_oe_o(oe), .pin_out_o(pout),
		.port_read_o(prd), .crystal_drive_o(drv), .overflow_irq_o(irq),
		.sysclk_from_timer_osc_o(stat));
	ext_clock_src src (.drive_i(drv), .fail_i(fail), .ext_pin_o(ext), .xtal_o(xtal),
		.running_o(run));
	// Each pin shows the device's drive where enabled, else the crystal.
	assign lvl = (oe & pout) | (~oe & xtal);
	// Core clock at 40 MHz.
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	// Prints the verdict and ends the run.
	task complete_run();
		if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Compares one value against its expectation within a tolerance.
	task cmp_val(input logic [31:0] got, input logic [31:0] want, input int tl);
		checked++;
		if ($isunknown(got) || got > want + tl || got + tl < want) begin
			err_total++;
			$display("FAIL %0t got %h want %h", $time, got, want);
		end
	endtask
	// One classic Wishbone cycle, held until ack is sampled.
	task wb_xfer(input logic [7:0] a, input logic [31:0] d, input logic w);
		@(posedge clk_i);
		adr <= a;
		dat <= d;
		we <= w;
		cyc <= 1'b1;
		stb <= 1'b1;
		do @(posedge clk_i); while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// Notes the expected read data, then reads.
	task rd(input logic [7:0] a, input logic [31:0] x, input int tl);
		exp_q.push_back(x);
		tol_q.push_back(tl);
		wb_xfer(a, 32'h0, 1'b0);
	endtask
	// Takes the oldest note whenever read data comes back.
	always @(posedge clk_i) begin
		if (ack === 1'b1 && we === 1'b0) begin
			if (exp_q.size() == 0) cmp_val(rdat, 32'hdead, 0);
			else cmp_val(rdat, exp_q.pop_front(), tol_q.pop_front());
		end
	end
	// Cuts a hang short.
	initial begin
		#2000000;
		err_total++;
		complete_run();
	end
	// Main sequence.
	initial begin
		{we, cyc, stb, sev, fail, adr, dat} = '0;
		system_clock_select = 2'h0;
		dir = 2'b00;
		pdat = 2'b11;
		seed = 32'h9800;
		err_total = 0;
		checked = 0;
		rst_i = 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`OFS_CONTROL, 32'h0, 0);
		rd(`OFS_COUNT_HIGH, 32'h0, 0);
		rd(8'h20, 32'h0, 0);
		wb_xfer(`OFS_CONTROL, 32'hff, 1'b1);
		rd(`OFS_CONTROL, 32'h3f, 0);
		wb_xfer(`OFS_CONTROL, 32'h0, 1'b1);
		repeat (4) @(posedge clk_i);
		cmp_val({30'h0, oe}, 32'h3, 0);
		// A stopped count keeps a random value.
		e = $random(seed) & 32'hff;
		wb_xfer(`OFS_COUNT_LOW, e, 1'b1);
		repeat (40) @(posedge clk_i);
		cmp_val({28'h0, pout, prd}, 32'hf, 0);
		rd(`OFS_COUNT_LOW, e, 0);
		// Wrap from all ones raises and holds the flag.
		wb_xfer(`OFS_COUNT_LOW, 32'hff, 1'b1);
		wb_xfer(`OFS_COUNT_HIGH, 32'hff, 1'b1);
		wb_xfer(`OFS_ENABLE_REG, 32'h1, 1'b1);
		wb_xfer(`OFS_CONTROL, 32'h1, 1'b1);
		repeat (12) @(posedge clk_i);
		wb_xfer(`OFS_CONTROL, 32'h0, 1'b1);
		rd(`OFS_COUNT_HIGH, 32'h0, 0);
		rd(`OFS_FLAG_REG, 32'h1, 0);
		cmp_val({31'h0, irq}, 32'h1, 0);
		wb_xfer(`OFS_ENABLE_REG, 32'h0, 1'b1);
		repeat (2) @(posedge clk_i);
		cmp_val({31'h0, irq}, 32'h0, 0);
		wb_xfer(`OFS_FLAG_REG, 32'h0, 1'b1);
		// The trigger clears the count without raising the flag.
		wb_xfer(`OFS_COUNT_HIGH, 32'h12, 1'b1);
		@(posedge clk_i) sev <= 1'b1;
		@(posedge clk_i) sev <= 1'b0;
		rd(`OFS_COUNT_HIGH, 32'h0, 0);
		rd(`OFS_FLAG_REG, 32'h0, 0);
		// Timer mode at every prescale setting.
		for (t = 0; t < 4; t++) begin
			wb_xfer(`OFS_COUNT_LOW, 32'h0, 1'b1);
			wb_xfer(`OFS_CONTROL, (t << 4) | 1, 1'b1);
			repeat (256) @(posedge clk_i);
			wb_xfer(`OFS_CONTROL, 32'h0, 1'b1);
			rd(`OFS_COUNT_LOW, 260 / (4 << t), 2);
		end
		// External edges, synchronised and not.
		for (t = 0; t < 2; t++) begin
			wb_xfer(`OFS_COUNT_LOW, 32'h0, 1'b1);
			wb_xfer(`OFS_CONTROL, 32'h3 | (t << 2), 1'b1);
			n = 1 + ($random(seed) & 15);
			src.pulses(n);
			repeat (8) @(posedge clk_i);
			rd(`OFS_COUNT_LOW, n, 0);
		end
		// Crystal on, timer oscillator chosen as system clock.
		system_clock_select <= `SCS_TIMER_OSC;
		wb_xfer(`OFS_CONTROL, 32'h8, 1'b1);
		#3000;
		@(posedge clk_i);
		cmp_val({29'h0, drv, oe}, 32'h4, 0);
		cmp_val({30'h0, prd}, 32'h0, 0);
		rd(`OFS_CONTROL, 32'h48, 0);
		fail <= 1'b1;
		repeat (8) @(posedge clk_i);
		rd(`OFS_CONTROL, 32'h8, 0);
		cmp_val({31'h0, stat}, 32'h0, 0);
		wb_xfer(`OFS_CONTROL, 32'h0, 1'b1);
		repeat (4) @(posedge clk_i);
		cmp_val({31'h0, drv}, 32'h0, 0);
		complete_run();
	end
endmodule // sixteen_bit_timer_counter_tb
